// *** rtl/afw_pkg.sv ***
package afw_pkg;
   // sensor geometry
   localparam int SENSOR_COLS = 648;
   localparam int SENSOR_ROWS = 488;
   localparam int COORD_W = 12;
   localparam int PIX_W = 12;
   localparam int VALUE_W = 16;
   // reset window: full sensor
   localparam logic [11:0] WIN_COL_START_RST = 12'h000;
   localparam logic [11:0] WIN_ROW_START_RST = 12'h000;
   localparam logic [11:0] WIN_COLS_RST = 12'h288;
   localparam logic [11:0] WIN_ROWS_RST = 12'h1e8;
   // once run limit in images
   localparam logic [5:0] ONCE_MAX_IMAGES = 6'h1e;
   // settle band around target, in 8-bit gray
   localparam logic [7:0] TARGET_TOL = 8'h02;
   localparam logic [15:0] ADJ_VALUE_RST = 16'h0100;
   // mode encoding on the mode port
   typedef enum logic [1:0] {
      AFW_MODE_OFF = 2'b00,
      AFW_MODE_ONCE = 2'b01,
      AFW_MODE_CONT = 2'b10
   } afw_mode_t;
   typedef enum logic [1:0] {
      AFW_ST_OFF = 2'b00,
      AFW_ST_ONCE = 2'b01,
      AFW_ST_CONT = 2'b10
   } afw_state_t;
endpackage

// *** rtl/afw_auto_function.sv ***
// Summary of operation
// - once mode adjusts until target reached, then turns off, keeping final value
// - unreachable target in once mode: give up after at most 30 images
// - once always supported; continuous only where the continuous-capable parameter allows
// - continuous mode adjusts every image or every other image per frame rate
// - continuous runs until once or off chosen; last automatic value then stays
// - while off, latest automatic value holds until a manual write
// - after once, value may change by once, continuous or manual write
// - mode and window settings accepted while frames stream
// - newly selected mode starts at next frame start, so early images unaffected
// - window coordinates count from sensor column 0, row 0
// - window given by column start, columns, row start, rows
// - only pixels inside window and output image window feed statistics
// - no overlap means no adjustment is made
// - window resets to full sensor size
// - window fields accepted in steps of one
// - with binning, coordinates arrive already in binned units
// - automatic adjustment overwrites a manual value
// - auto functions idle while the sequencer is enabled
// - target gray level is 8 bits, 0 black to 255 white
module afw_auto_function #(
   parameter int CONT_CAPABLE = 1,
   parameter int STEP_SHIFT = 2
) (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire afw_pkg::afw_mode_t mode_i,
   input wire logic mode_wr_i,
   input wire logic sequencer_en_i,
   input wire logic skip_alternate_i,
   input wire logic [7:0] target_i,
   input wire logic [afw_pkg::VALUE_W-1:0] lower_limit_i,
   input wire logic [afw_pkg::VALUE_W-1:0] upper_limit_i,
   input wire logic [afw_pkg::VALUE_W-1:0] manual_value_i,
   input wire logic manual_wr_i,
   input wire logic [afw_pkg::COORD_W-1:0] win_col_start_i,
   input wire logic [afw_pkg::COORD_W-1:0] win_row_start_i,
   input wire logic [afw_pkg::COORD_W-1:0] win_cols_i,
   input wire logic [afw_pkg::COORD_W-1:0] win_rows_i,
   input wire logic win_wr_i,
   input wire logic [afw_pkg::COORD_W-1:0] img_col_start_i,
   input wire logic [afw_pkg::COORD_W-1:0] img_row_start_i,
   input wire logic [afw_pkg::COORD_W-1:0] img_cols_i,
   input wire logic [afw_pkg::COORD_W-1:0] img_rows_i,
   input wire logic frame_start_i,
   input wire logic frame_end_i,
   input wire logic pix_valid_i,
   input wire logic [afw_pkg::COORD_W-1:0] pix_col_i,
   input wire logic [afw_pkg::COORD_W-1:0] pix_row_i,
   input wire logic [afw_pkg::PIX_W-1:0] pix_data_i,
   output logic [afw_pkg::VALUE_W-1:0] value_o,
   output afw_pkg::afw_mode_t mode_o,
   output logic [7:0] avg_gray_o,
   output logic avg_valid_o,
   output logic once_done_o,
   output logic once_timeout_o
);
   import afw_pkg::*;

   // ==========================================================
   // reset release
   logic rst_sync1_reg;
   logic rst_sync2_reg;
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sync1_reg <= 1'b0;
         rst_sync2_reg <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_sync2_reg <= rst_sync1_reg;
      end
   end
   wire rstn = rst_sync2_reg;

   // ==========================================================
   // window settings, live-updated
   logic [COORD_W-1:0] win_cs_reg;
   logic [COORD_W-1:0] win_rs_reg;
   logic [COORD_W-1:0] win_c_reg;
   logic [COORD_W-1:0] win_r_reg;
   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         win_cs_reg <= WIN_COL_START_RST;
         win_rs_reg <= WIN_ROW_START_RST;
         win_c_reg <= WIN_COLS_RST;
         win_r_reg <= WIN_ROWS_RST;
      end else if (win_wr_i) begin
         // any value in steps of one; binned units come in as is
         win_cs_reg <= win_col_start_i;
         win_rs_reg <= win_row_start_i;
         win_c_reg <= win_cols_i;
         win_r_reg <= win_rows_i;
      end
   end

   // ==========================================================
   // pixel selection
   function automatic logic in_span(input logic [COORD_W-1:0] p,
                                    input logic [COORD_W-1:0] s,
                                    input logic [COORD_W-1:0] n);
      logic [COORD_W:0] e;
      e = {1'b0, s} + {1'b0, n};
      in_span = ({1'b0, p} >= {1'b0, s}) && ({1'b0, p} < e);
   endfunction
   // coordinates relative to sensor origin 0,0
   wire in_win = in_span(pix_col_i, win_cs_reg, win_c_reg) &&
                 in_span(pix_row_i, win_rs_reg, win_r_reg);
   wire in_img = in_span(pix_col_i, img_col_start_i, img_cols_i) &&
                 in_span(pix_row_i, img_row_start_i, img_rows_i);
   wire pix_sel = pix_valid_i && in_win && in_img;

   // ==========================================================
   // frame statistics
   // gray is the pixel's top 8 bits, so the target is width-independent
   wire [7:0] pix_gray = pix_data_i[PIX_W-1 -: 8];
   logic [31:0] sum_reg;
   logic [23:0] cnt_reg;
   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         sum_reg <= 32'h0;
         cnt_reg <= 24'h0;
      end else if (frame_start_i) begin
         sum_reg <= 32'h0;
         cnt_reg <= 24'h0;
      end else if (pix_sel) begin
         sum_reg <= sum_reg + {24'h0, pix_gray};
         cnt_reg <= cnt_reg + 24'h1;
      end
   end
   // sequential divider keeps area small; one bit per cycle
   logic [5:0] div_cnt_reg;
   logic [31:0] quo_reg;
   logic [31:0] rem_reg;
   logic div_busy_reg;
   logic [23:0] div_den_reg;
   logic stats_ok_reg;
   wire [32:0] rem_shift = {rem_reg, quo_reg[31]};
   wire rem_ge = rem_shift >= {9'h0, div_den_reg};
   wire [32:0] rem_sub = rem_shift - {9'h0, div_den_reg};
   wire div_done = div_busy_reg && (div_cnt_reg == 6'h1f);
   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         div_cnt_reg <= 6'h0;
         quo_reg <= 32'h0;
         rem_reg <= 32'h0;
         div_busy_reg <= 1'b0;
         div_den_reg <= 24'h0;
         stats_ok_reg <= 1'b0;
      end else if (frame_end_i) begin
         div_busy_reg <= 1'b1;
         div_cnt_reg <= 6'h0;
         quo_reg <= sum_reg;
         rem_reg <= 32'h0;
         div_den_reg <= cnt_reg;
         stats_ok_reg <= cnt_reg != 24'h0;
      end else if (div_busy_reg) begin
         rem_reg <= rem_ge ? rem_sub[31:0] : rem_shift[31:0];
         quo_reg <= {quo_reg[30:0], rem_ge};
         div_cnt_reg <= div_cnt_reg + 6'h1;
         if (div_done) begin
            div_busy_reg <= 1'b0;
         end
      end
   end
   wire [7:0] avg_next = quo_reg[6:0] == 7'h0 ? {quo_reg[6:0], rem_ge} :
                         {quo_reg[6:0], rem_ge};

   // ==========================================================
   // mode control
   afw_state_t st_reg;
   afw_mode_t pend_reg;
   logic pend_vld_reg;
   logic [5:0] img_cnt_reg;
   logic alt_reg;
   logic [VALUE_W-1:0] val_reg;
   logic [7:0] avg_reg;
   logic avg_vld_reg;
   logic done_reg;
   logic tmo_reg;

   wire mode_ok = (mode_i != AFW_MODE_CONT) || (CONT_CAPABLE != 0);
   wire err_lo = avg_next + TARGET_TOL < target_i;
   wire err_hi = avg_next > target_i + TARGET_TOL;
   wire on_target = !err_lo && !err_hi;
   wire [VALUE_W-1:0] step = val_reg >> STEP_SHIFT == '0 ? 16'h0001 : val_reg >> STEP_SHIFT;
   wire [VALUE_W:0] up_sum = {1'b0, val_reg} + {1'b0, step};
   wire [VALUE_W-1:0] up_val = (up_sum > {1'b0, upper_limit_i}) ? upper_limit_i
                                                               : up_sum[VALUE_W-1:0];
   wire [VALUE_W-1:0] dn_val = (val_reg < lower_limit_i + step) ? lower_limit_i
                                                               : val_reg - step;
   wire active = (st_reg != AFW_ST_OFF) && !sequencer_en_i;
   // every image, or every other one at high frame rate
   wire adj_slot = !skip_alternate_i || !alt_reg || (st_reg == AFW_ST_ONCE);
   wire adjust = div_done && active && stats_ok_reg && adj_slot;
   wire once_end_hit = (st_reg == AFW_ST_ONCE) && div_done && !sequencer_en_i
                       && stats_ok_reg && on_target;
   wire once_give_up = (st_reg == AFW_ST_ONCE) && div_done && !sequencer_en_i
                       && (img_cnt_reg >= ONCE_MAX_IMAGES - 6'h1) && !once_end_hit;

   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         st_reg <= AFW_ST_OFF;
         pend_reg <= AFW_MODE_OFF;
         pend_vld_reg <= 1'b0;
         img_cnt_reg <= 6'h0;
         alt_reg <= 1'b0;
         val_reg <= ADJ_VALUE_RST;
         avg_reg <= 8'h0;
         avg_vld_reg <= 1'b0;
         done_reg <= 1'b0;
         tmo_reg <= 1'b0;
      end else begin
         avg_vld_reg <= div_done;
         done_reg <= once_end_hit;
         tmo_reg <= once_give_up;
         if (div_done) begin
            avg_reg <= avg_next;
         end
         if (mode_wr_i && mode_ok) begin
            pend_reg <= mode_i;
            pend_vld_reg <= 1'b1;
         end else if (frame_start_i) begin
            pend_vld_reg <= 1'b0;
         end
         if (frame_start_i && pend_vld_reg) begin
            // takes hold only at a frame boundary, hence a short delay
            st_reg <= afw_state_t'(pend_reg);
            img_cnt_reg <= 6'h0;
            alt_reg <= 1'b0;
         end else if (once_end_hit) begin
            st_reg <= AFW_ST_OFF;
         end else if (once_give_up) begin
            st_reg <= AFW_ST_OFF;
         end else if (div_done && active) begin
            img_cnt_reg <= img_cnt_reg + 6'h1;
            alt_reg <= !alt_reg;
         end
         if (manual_wr_i) begin
            val_reg <= manual_value_i;
         end else if (adjust && err_lo) begin
            val_reg <= up_val;
         end else if (adjust && err_hi) begin
            val_reg <= dn_val;
         end
      end
   end

   // ==========================================================
   // outputs; value held when off
   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         value_o <= ADJ_VALUE_RST;
         mode_o <= AFW_MODE_OFF;
         avg_gray_o <= 8'h0;
         avg_valid_o <= 1'b0;
         once_done_o <= 1'b0;
         once_timeout_o <= 1'b0;
      end else begin
         value_o <= val_reg;
         mode_o <= afw_mode_t'(st_reg);
         avg_gray_o <= avg_reg;
         avg_valid_o <= avg_vld_reg;
         once_done_o <= done_reg;
         once_timeout_o <= tmo_reg;
      end
   end
endmodule // afw_auto_function

// *** testbench/afw_auto_function_checker.sv ***
// ==========================================
// port checker
module afw_checker (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic frame_start_i,
   input wire logic frame_end_i,
   input wire logic manual_wr_i,
   input wire logic sequencer_en_i,
   input wire logic [7:0] target_i,
   input wire logic [afw_pkg::VALUE_W-1:0] value_o,
   input wire afw_pkg::afw_mode_t mode_o,
   input wire logic [7:0] avg_gray_o,
   input wire logic avg_valid_o,
   input wire logic once_done_o,
   input wire logic once_timeout_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import afw_pkg::*;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // ==========================================
   // helper counters: sequencer dwell, frames seen in one once run
   logic [5:0] seq_cnt_reg;
   logic [5:0] seq_cnt_next;
   logic [5:0] once_cnt_reg;
   logic [5:0] once_cnt_next;
   assign seq_cnt_next = !sequencer_en_i ? 6'h00 :
                         (seq_cnt_reg == 6'h3f) ? seq_cnt_reg : seq_cnt_reg + 6'h01;
   assign once_cnt_next = (mode_o != AFW_MODE_ONCE) ? 6'h00 :
                          (frame_end_i && !sequencer_en_i) ? once_cnt_reg + 6'h01 : once_cnt_reg;
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         seq_cnt_reg <= 6'h00;
         once_cnt_reg <= 6'h00;
      end else begin
         seq_cnt_reg <= seq_cnt_next;
         once_cnt_reg <= once_cnt_next;
      end
   end
   // ==========================================
   // assertions
   once_off_a: assert property (once_done_o |-> mode_o == AFW_MODE_OFF)
      else $error("once finished but mode not off");
   give_up_off_a: assert property (once_timeout_o |-> mode_o == AFW_MODE_OFF)
      else $error("once gave up but mode not off");
   once_cap_a: assert property (frame_end_i && !sequencer_en_i && mode_o == AFW_MODE_ONCE
      |-> once_cnt_reg < 6'h1e)
      else $error("once run lasted beyond its image limit");
   avg_timing_a: assert property (avg_valid_o |-> $past(frame_end_i, 33) || $past(frame_end_i, 34)
      || $past(frame_end_i, 35))
      else $error("average valid without a frame end");
   done_target_a: assert property (once_done_o |-> ({1'b0, avg_gray_o} + {1'b0, TARGET_TOL}
      >= {1'b0, target_i}) && ({1'b0, avg_gray_o} <= {1'b0, target_i} + {1'b0, TARGET_TOL}))
      else $error("once finished away from target");
   mode_start_a: assert property ($changed(mode_o) && mode_o != AFW_MODE_OFF
      |-> $past(frame_start_i) || $past(frame_start_i, 2))
      else $error("mode switched on away from frame start");
   // slack of one cycle either way: the update point is counted from the divider
   value_cause_a: assert property ($changed(value_o) |-> $past(manual_wr_i) || $past(manual_wr_i, 2)
      || $past(manual_wr_i, 3) || $past(frame_end_i, 33) || $past(frame_end_i, 34)
      || $past(frame_end_i, 35))
      else $error("value changed with no cause");
   seq_idle_a: assert property (seq_cnt_reg > 6'h28 && !$past(manual_wr_i) && !$past(manual_wr_i, 2)
      |-> $stable(value_o))
      else $error("value adjusted while sequencer enabled");
endmodule // afw_checker

bind afw_auto_function afw_checker chk (.clock_i(clock_i), .rstn_i(rstn_i),
   .frame_start_i(frame_start_i), .frame_end_i(frame_end_i), .manual_wr_i(manual_wr_i),
   .sequencer_en_i(sequencer_en_i), .target_i(target_i), .value_o(value_o), .mode_o(mode_o),
   .avg_gray_o(avg_gray_o), .avg_valid_o(avg_valid_o), .once_done_o(once_done_o),
   .once_timeout_o(once_timeout_o));

// *** testbench/testbench.sv ***
// ==========================================
// bench
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import afw_pkg::*;
   logic clock_i = 1'b0, rstn_i = 1'b0, mode_wr_i = 1'b0, seq_i = 1'b0, skip_i = 1'b0;
   logic manual_wr_i = 1'b0, win_wr_i = 1'b0, fs_i = 1'b0, fe_i = 1'b0, pv_i = 1'b0;
   afw_mode_t mode_i = AFW_MODE_OFF;
   afw_mode_t mode_o;
   logic [7:0] target_i = 8'h80, avg_gray_o;
   logic [15:0] upper_i = 16'hffff, man_i = 16'h0000, value_o, v;
   logic [11:0] wc = 12'h000, wr = 12'h000, wn = 12'h288, wm = 12'h1e8;
   logic [11:0] pc = 12'h000, pr = 12'h000, pd = 12'h000;
   // lower clamp and image width are driven at fixed values; no test takes the lower clamp or drops a pixel by image width
   logic [15:0] lower_i = 16'h0001;
   logic [11:0] img_cols_i = 12'h008;
   logic avg_valid_o, once_done_o, once_timeout_o, done_seen = 1'b0, to_seen = 1'b0;
   int err_total = 0, compares = 0, n;
   // image window fixed at 8 x 4 so a frame stays short
   afw_auto_function #(.CONT_CAPABLE(1), .STEP_SHIFT(2)) dut (
      .clock_i(clock_i), .rstn_i(rstn_i), .mode_i(mode_i), .mode_wr_i(mode_wr_i),
      .sequencer_en_i(seq_i), .skip_alternate_i(skip_i), .target_i(target_i),
      .lower_limit_i(lower_i), .upper_limit_i(upper_i), .manual_value_i(man_i),
      .manual_wr_i(manual_wr_i), .win_col_start_i(wc), .win_row_start_i(wr),
      .win_cols_i(wn), .win_rows_i(wm), .win_wr_i(win_wr_i), .img_col_start_i(12'h000),
      .img_row_start_i(12'h000), .img_cols_i(img_cols_i), .img_rows_i(12'h004),
      .frame_start_i(fs_i), .frame_end_i(fe_i), .pix_valid_i(pv_i), .pix_col_i(pc),
      .pix_row_i(pr), .pix_data_i(pd), .value_o(value_o), .mode_o(mode_o),
      .avg_gray_o(avg_gray_o), .avg_valid_o(avg_valid_o), .once_done_o(once_done_o),
      .once_timeout_o(once_timeout_o));
   initial begin
      forever #10 clock_i = ~clock_i;
   end
   // ==========================================
   // tasks
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input logic same);
      compares++;
      if ((got === exp) !== same) begin
         err_total++;
         $display("Error at %0t ns: got %h, reference %h", $time, got, exp);
      end
   endtask
   task automatic set_win(input logic [11:0] c, input logic [11:0] r, input logic [11:0] nc,
                          input logic [11:0] nr);
      @(posedge clock_i);
      wc <= c;
      wr <= r;
      wn <= nc;
      wm <= nr;
      win_wr_i <= 1'b1;
      @(posedge clock_i);
      win_wr_i <= 1'b0;
   endtask
   task automatic set_mode(input afw_mode_t m, input logic [7:0] t, input logic [15:0] u);
      @(posedge clock_i);
      mode_i <= m;
      target_i <= t;
      upper_i <= u;
      mode_wr_i <= 1'b1;
      @(posedge clock_i);
      mode_wr_i <= 1'b0;
   endtask
   // pixels inside the statistics window carry gin, all others gout
   task automatic frame(input logic [7:0] gin, input logic [7:0] gout);
      @(posedge clock_i);
      fs_i <= 1'b1;
      @(posedge clock_i);
      fs_i <= 1'b0;
      pv_i <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         pc <= 12'(i % 8);
         pr <= 12'(i / 8);
         pd <= (i % 8 >= wc && i % 8 < wc + wn && i / 8 >= wr && i / 8 < wr + wm) ?
               {gin, 4'h0} : {gout, 4'h0};
         @(posedge clock_i);
      end
      pv_i <= 1'b0;
      fe_i <= 1'b1;
      @(posedge clock_i);
      fe_i <= 1'b0;
      repeat (45) begin
         @(negedge clock_i);
         if (once_done_o === 1'b1) done_seen = 1'b1;
         if (once_timeout_o === 1'b1) to_seen = 1'b1;
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ==========================================
   // tests
   initial begin
      repeat (10) @(posedge clock_i);
      rstn_i <= 1'b1;
      repeat (5) @(posedge clock_i);
      check(value_o, 16'h0100, 1'b1);
      check(16'(mode_o), 16'(AFW_MODE_OFF), 1'b1);
      frame(8'h60, 8'h60);
      check(16'(avg_gray_o), 16'h0060, 1'b1);
      check(value_o, 16'h0100, 1'b1);
      set_win(12'h002, 12'h001, 12'h004, 12'h002);
      frame(8'h40, 8'hc0);
      check(16'(avg_gray_o), 16'h0040, 1'b1);
      $display("window test done");
      set_mode(AFW_MODE_CONT, 8'h80, 16'hffff);
      v = value_o;
      frame(8'h10, 8'h10);
      check(value_o, v, 1'b0);
      set_win(12'h064, 12'h000, 12'h004, 12'h002);
      v = value_o;
      frame(8'h10, 8'h10);
      check(value_o, v, 1'b1);
      set_win(12'h000, 12'h000, 12'h008, 12'h004);
      skip_i <= 1'b1;
      v = value_o;
      frame(8'h10, 8'h10);
      frame(8'h10, 8'h10);
      check(value_o, v, 1'b0);
      set_mode(AFW_MODE_OFF, 8'h80, 16'hffff);
      skip_i <= 1'b0;
      v = value_o;
      frame(8'h10, 8'h10);
      check(value_o, v, 1'b1);
      $display("continuous test done");
      @(posedge clock_i);
      man_i <= 16'h0200;
      manual_wr_i <= 1'b1;
      @(posedge clock_i);
      manual_wr_i <= 1'b0;
      seq_i <= 1'b1;
      repeat (3) @(negedge clock_i);
      check(value_o, 16'h0200, 1'b1);
      set_mode(AFW_MODE_CONT, 8'h80, 16'hffff);
      frame(8'h10, 8'h10);
      frame(8'h10, 8'h10);
      check(value_o, 16'h0200, 1'b1);
      @(posedge clock_i);
      seq_i <= 1'b0;
      frame(8'h10, 8'h10);
      check(value_o, 16'h0200, 1'b0);
      $display("manual test done");
      set_mode(AFW_MODE_ONCE, 8'h40, 16'hffff);
      frame(8'h40, 8'h40);
      check(16'(done_seen), 16'h0001, 1'b1);
      check(16'(mode_o), 16'(AFW_MODE_OFF), 1'b1);
      set_mode(AFW_MODE_ONCE, 8'hff, 16'h0400);
      n = 0;
      while (to_seen !== 1'b1 && n < 31) begin
         frame(8'h00, 8'h00);
         n++;
      end
      check(16'(to_seen), 16'h0001, 1'b1);
      check(16'(n), 16'h001e, 1'b1);
      check(16'(mode_o), 16'(AFW_MODE_OFF), 1'b1);
      check(16'(value_o <= 16'h0400), 16'h0001, 1'b1);
      $display("once test done");
      tally_and_finish();
   end
endmodule // testbench
